// >>> core/ccr_clk_div.sv
// Purpose: divided master clock and serial clock enables
// Assumes: divide ratio of the master clock is select plus one
// Notes:   both enables come from flops, one-cycle pulses except at a total divide ratio of one, where they stay high
module ccr_clk_div (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] mcd_sel_i,
  input  wire logic [1:0] scd_sel_i,
  output logic            divided_master_clock_en_o,
  output logic            sclk_en_o
);
  ccr_pkg::ccr_div_st_t st_reg;
  ccr_pkg::ccr_div_st_t st_next;
  logic [3:0]           sc_period;

  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  // serial clock period in divided clocks: 8, 4, 2, 1
  assign sc_period = ccr_pkg::SCLK_DIV_BASE >> scd_sel_i;

  always_comb
  begin
    st_next       = st_reg;
    st_next.dm_en = 1'b0;
    st_next.sc_en = 1'b0;
    if (st_reg.mcnt >= mcd_sel_i)
    begin
      st_next.mcnt  = 3'h0;
      st_next.dm_en = 1'b1;
      if (st_reg.scnt >= sc_period[2:0] - 3'h1 || sc_period == 4'h8 && st_reg.scnt == 3'h7)
      begin
        st_next.scnt  = 3'h0;
        st_next.sc_en = 1'b1;
      end
      else
      begin
        st_next.scnt = st_reg.scnt + 3'h1;
      end
    end
    else
    begin
      st_next.mcnt = st_reg.mcnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign divided_master_clock_en_o = st_reg.dm_en;
  assign sclk_en_o  = st_reg.sc_en;
endmodule

// >>> core/ccr_fsync.sv
// Purpose: output frame sync at the sample rate
// Assumes: hw reset pin is synchronous to the system clock
// Notes:   first pulse a fixed count after the pin rises
module ccr_fsync (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       divided_master_clock_en_i,
  input  wire logic       hw_reset_pin_n_i,
  input  wire logic [1:0] rate_sel_i,
  output logic            output_frame_sync_o
);
  ccr_pkg::ccr_fs_st_t st_reg;
  ccr_pkg::ccr_fs_st_t st_next;
  logic [11:0]         period;

  // ------------------------------------------------------------
  // sample period: 2048, 1024, 512, 256 divided clocks
  // ------------------------------------------------------------
  assign period = ccr_pkg::RATE_DIV_BASE >> rate_sel_i;

  always_comb
  begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (!hw_reset_pin_n_i)
    begin
      st_next.cnt   = 12'h000;
      st_next.first = 1'b1;
    end
    else if (divided_master_clock_en_i)
    begin
      // first sync 280 divided clocks after release
      if (st_reg.first && st_reg.cnt == ccr_pkg::FSYNC_FIRST - 12'h001)
      begin
        st_next.cnt   = 12'h000;
        st_next.first = 1'b0;
        st_next.pulse = 1'b1;
      end
      else if (!st_reg.first && st_reg.cnt >= period - 12'h001)
      begin
        st_next.cnt   = 12'h000;
        st_next.pulse = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign output_frame_sync_o = st_reg.pulse;
endmodule

// >>> core/ccr_regbank.sv
// Purpose: control register bank of a dual codec front end
// Assumes: control words arrive deframed on a valid/ready strobe
// Notes:   writes update registers on the divided master clock enable; the pin clears them on any clock edge
module ccr_regbank (
  input  wire logic                        clk_sys_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        hw_reset_pin_n_i,
  input  wire logic                        ctl_valid_i,
  input  ccr_pkg::ccr_word_t               ctl_word_i,
  output logic                             ctl_ready_o,
  output ccr_pkg::ccr_word_t               out_word_o,
  output logic                             out_valid_o,
  output ccr_pkg::ccr_cfg_t  [1:0]         cfg_o,
  output ccr_pkg::ccr_stat_t [1:0]         stat_o,
  output logic                             ref_shared_o,
  output logic                             ref_out_o,
  output logic                             divided_master_clock_en_o,
  output logic                             sclk_en_o,
  output logic                             output_frame_sync_o
);

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  // control words are taken only when flagged, in program mode or in mixed mode
  function automatic logic accepts(input logic [7:0] mode_reg, input logic cd);
    accepts = cd && !(mode_reg[ccr_pkg::RUN_BIT] && !mode_reg[ccr_pkg::MIXED_BIT]);
  endfunction

  // effective section power and derived status of one unit
  function automatic ccr_pkg::ccr_stat_t unit_status(input ccr_pkg::ccr_cfg_t c);
    ccr_pkg::ccr_stat_t s;
    s.analog_tap_power   = c.analog_tap_power | c.global_power_on;
    s.front_amp_power    = c.front_amp_power | c.global_power_on;
    s.adc_power          = c.adc_power | c.global_power_on;
    s.dac_power          = c.dac_power | c.global_power_on;
    s.reference_power    = c.reference_power | c.global_power_on;
    s.analog_tap_on      = c.single_ended_select;
    s.analog_tap_silence = c.analog_loop_select;
    s.samples_valid      = c.run_mode_sel;
    unit_status = s;
  endfunction

  // reference output use bit of one unit
  function automatic logic ref_use(input ccr_pkg::ccr_cfg_t c);
    ref_use = c.ref_out_use;
  endfunction

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  ccr_pkg::ccr_main_st_t st_reg;
  ccr_pkg::ccr_main_st_t st_next;
  logic                  divided_master_clock_en;
  logic                  apply;
  logic                  hit;
  logic                  unit_sel;
  ccr_pkg::ccr_cfg_t     cfg0;

  assign cfg0     = ccr_pkg::ccr_cfg_t'(st_reg.regs[0]);
  assign unit_sel = st_reg.pend.dev[0];

  // pending word lands on a divided clock edge outside reset
  assign apply = divided_master_clock_en && st_reg.pend_vld && st_reg.busy == 3'h0 && hw_reset_pin_n_i;
  assign hit   = apply && st_reg.pend.dev < 3'(ccr_pkg::NUM_UNITS)
               && accepts(st_reg.regs[unit_sel][ccr_pkg::REG_MODE], st_reg.pend.cd);

  // ------------------------------------------------------------
  // clock enables and frame sync
  // ------------------------------------------------------------
  ccr_clk_div u_clk_div (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .mcd_sel_i  (cfg0.master_clock_divide_sel),
    .scd_sel_i  (cfg0.serial_clock_divide_sel),
    .divided_master_clock_en_o (divided_master_clock_en),
    .sclk_en_o  (sclk_en_o)
  );

  ccr_fsync u_fsync (
    .clk_sys_i           (clk_sys_i),
    .reset_n_i           (reset_n_i),
    .divided_master_clock_en_i          (divided_master_clock_en),
    .hw_reset_pin_n_i    (hw_reset_pin_n_i),
    .rate_sel_i          (cfg0.rate_sel),
    .output_frame_sync_o (output_frame_sync_o)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next         = st_reg;
    st_next.out_vld = 1'b0;
    if (!hw_reset_pin_n_i)
    begin
      // pin held low: clear and restart the reset interval
      st_next.regs     = '0;
      st_next.busy     = ccr_pkg::RESET_DIVIDED_MASTER_CLOCK;
      st_next.pend_vld = 1'b0;
    end
    else
    begin
      if (divided_master_clock_en && st_reg.busy != 3'h0)
        st_next.busy = st_reg.busy - 3'h1;
      if (ctl_valid_i && st_reg.ready)
      begin
        st_next.pend     = ctl_word_i;
        st_next.pend_vld = 1'b1;
      end
      if (apply)
      begin
        st_next.pend_vld = 1'b0;
        if (st_reg.pend.dev >= 3'(ccr_pkg::NUM_UNITS))
        begin
          // not ours: pass on with address reduced by our units
          st_next.out_word     = st_reg.pend;
          st_next.out_word.dev = st_reg.pend.dev - ccr_pkg::DEV_STEP;
          st_next.out_vld      = 1'b1;
        end
        else if (hit && st_reg.pend.rw)
        begin
          // read: data field replaced by register content
          st_next.out_word      = st_reg.pend;
          st_next.out_word.data = st_reg.regs[unit_sel][st_reg.pend.addr];
          st_next.out_vld       = 1'b1;
        end
        else if (hit)
        begin
          if (st_reg.pend.addr == ccr_pkg::REG_MODE && st_reg.pend.data[ccr_pkg::SOFT_RST_BIT])
          begin
            st_next.regs = '0;
            st_next.busy = ccr_pkg::RESET_DIVIDED_MASTER_CLOCK;
          end
          else if (st_reg.pend.addr == ccr_pkg::REG_POWER)
          begin
            st_next.regs[unit_sel][ccr_pkg::REG_POWER] =
              st_reg.pend.data & ccr_pkg::POWER_MASK;
          end
          else
          begin
            st_next.regs[unit_sel][st_reg.pend.addr] = st_reg.pend.data;
          end
          // echo the write word when enabled on that unit
          if (st_reg.regs[unit_sel][ccr_pkg::REG_RATE][ccr_pkg::ECHO_BIT])
          begin
            st_next.out_word = st_reg.pend;
            st_next.out_vld  = 1'b1;
          end
        end
      end
    end
    // derived status follows the registers in the same cycle
    for (int u = 0; u < ccr_pkg::NUM_UNITS; u++)
    begin
      st_next.stat[u] = unit_status(ccr_pkg::ccr_cfg_t'(st_next.regs[u]));
    end
    st_next.ref_shared = st_next.stat[0].reference_power
                       | st_next.stat[1].reference_power;
    st_next.ref_out    = ref_use(st_next.regs[0])
                       | ref_use(st_next.regs[1]);
    st_next.ready      = !st_next.pend_vld && st_next.busy == 3'h0
                       && hw_reset_pin_n_i;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // outputs, all from state flops
  // ------------------------------------------------------------
  assign ctl_ready_o  = st_reg.ready;
  assign out_word_o   = st_reg.out_word;
  assign out_valid_o  = st_reg.out_vld;
  assign stat_o       = st_reg.stat;
  assign ref_shared_o = st_reg.ref_shared;
  assign ref_out_o    = st_reg.ref_out;
  assign divided_master_clock_en_o   = divided_master_clock_en;

  // register fields as typed settings: layouts
  genvar g;
  generate
    for (g = 0; g < ccr_pkg::NUM_UNITS; g++)
    begin : g_unit
      assign cfg_o[g] = ccr_pkg::ccr_cfg_t'(st_reg.regs[g]);

      property p_reserved;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        st_reg.regs[g][ccr_pkg::REG_POWER][7] == 1'b0;
      endproperty
      a_reserved: assert property (p_reserved)
        else $error("reserved power bit set");

      property p_power_or;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        st_reg.stat[g].dac_power == (st_reg.regs[g][ccr_pkg::REG_POWER][4]
                                   | st_reg.regs[g][ccr_pkg::REG_POWER][0])
        && st_reg.stat[g].analog_tap_power == (st_reg.regs[g][ccr_pkg::REG_POWER][1]
                                   | st_reg.regs[g][ccr_pkg::REG_POWER][0]);
      endproperty
      a_power_or: assert property (p_power_or)
        else $error("section power not own or global");

      property p_valid;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        st_reg.stat[g].samples_valid == st_reg.regs[g][ccr_pkg::REG_MODE][0];
      endproperty
      a_valid: assert property (p_valid)
        else $error("sample valid does not follow mode");
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_hw_clear;
    !hw_reset_pin_n_i |=> st_reg.regs == '0 && st_reg.busy == ccr_pkg::RESET_DIVIDED_MASTER_CLOCK
                          && !st_reg.ready;
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("pin reset did not clear registers");

  property p_soft;
    hit && !st_reg.pend.rw && st_reg.pend.addr == ccr_pkg::REG_MODE
      && st_reg.pend.data[7] |=> st_reg.regs == '0 && st_reg.busy == ccr_pkg::RESET_DIVIDED_MASTER_CLOCK;
  endproperty
  a_soft: assert property (p_soft)
    else $error("software reset did not clear registers");

  property p_busy_hold;
    st_reg.busy != 3'h0 |-> st_reg.regs == '0 && !st_reg.ready;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("registers changed during reset");

  property p_busy_step;
    st_reg.busy != 3'h0 && hw_reset_pin_n_i |=>
      st_reg.busy == $past(st_reg.busy) - ($past(divided_master_clock_en) ? 3'h1 : 3'h0);
  endproperty
  a_busy_step: assert property (p_busy_step)
    else $error("reset interval not counted in divided clocks");

  property p_write;
    hit && !st_reg.pend.rw && !(st_reg.pend.addr == ccr_pkg::REG_MODE && st_reg.pend.data[7])
      |=> st_reg.regs[unit_sel][st_reg.pend.addr][6:0] == st_reg.pend.data[6:0];
  endproperty
  a_write: assert property (p_write)
    else $error("write did not land");

  property p_read;
    hit && st_reg.pend.rw |=> st_reg.out_vld
      && st_reg.out_word.data == st_reg.regs[unit_sel][st_reg.pend.addr];
  endproperty
  a_read: assert property (p_read)
    else $error("read answer wrong");

  property p_ref;
    st_reg.ref_shared == (st_reg.regs[0][ccr_pkg::REG_POWER][5]
                        | st_reg.regs[0][ccr_pkg::REG_POWER][0]
                        | st_reg.regs[1][ccr_pkg::REG_POWER][5]
                        | st_reg.regs[1][ccr_pkg::REG_POWER][0]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("shared reference not OR of units");

  property p_ref_out;
    st_reg.ref_out == (st_reg.regs[0][ccr_pkg::REG_POWER][6]
                     | st_reg.regs[1][ccr_pkg::REG_POWER][6]);
  endproperty
  a_ref_out: assert property (p_ref_out)
    else $error("reference output not OR of use bits");

  property p_echo;
    hit && !st_reg.pend.rw && st_reg.regs[unit_sel][ccr_pkg::REG_RATE][ccr_pkg::ECHO_BIT]
      |=> st_reg.out_vld && st_reg.out_word == $past(st_reg.pend);
  endproperty
  a_echo: assert property (p_echo)
    else $error("written word not echoed");

  property p_drop;
    apply && st_reg.pend.dev < 3'(ccr_pkg::NUM_UNITS)
      && (!st_reg.pend.cd
          || st_reg.regs[unit_sel][ccr_pkg::REG_MODE][ccr_pkg::RUN_BIT]
             && !st_reg.regs[unit_sel][ccr_pkg::REG_MODE][ccr_pkg::MIXED_BIT])
      |=> st_reg.regs == $past(st_reg.regs) && !st_reg.out_vld;
  endproperty
  a_drop: assert property (p_drop)
    else $error("word taken in data mode");

  property p_hold;
    !apply && hw_reset_pin_n_i |=> st_reg.regs == $past(st_reg.regs);
  endproperty
  a_hold: assert property (p_hold)
    else $error("registers changed without a write");

  property p_ready_after;
    st_reg.busy == 3'h1 && divided_master_clock_en && hw_reset_pin_n_i |=> st_reg.ready;
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("port not ready after reset interval");

endmodule

// >>> shared/ccr_pkg.sv
// Purpose: shared constants and types of the codec control register bank
// Assumes: control words arrive already deframed, one 16-bit word per strobe
// Notes:   two codec units, eight 8-bit registers each
package ccr_pkg;

  // ------------------------------------------------------------
  // sizes and register indices
  // ------------------------------------------------------------
  localparam int       NUM_UNITS    = 2;
  localparam logic [2:0] REG_MODE   = 3'h0; // mode_control_reg
  localparam logic [2:0] REG_RATE   = 3'h1; // rate_clock_config
  localparam logic [2:0] REG_POWER  = 3'h2; // power_control
  localparam logic [2:0] REG_GAIN   = 3'h3; // gain_control
  localparam logic [2:0] REG_DACT   = 3'h4; // dac_timing_misc
  localparam logic [2:0] REG_ATAP   = 3'h5; // analog_tap_control
  localparam logic [2:0] REG_TAP_LO = 3'h6; // digital_tap_low
  localparam logic [2:0] REG_TAP_HI = 3'h7; // digital_tap_high

  // ------------------------------------------------------------
  // field positions, reset values, masks
  // ------------------------------------------------------------
  localparam int         RUN_BIT        = 0;
  localparam int         MIXED_BIT      = 1;
  localparam int         SOFT_RST_BIT   = 7;
  localparam int         ECHO_BIT       = 7;
  localparam logic [7:0] REG_RESET_VAL  = 8'h00;
  localparam logic [7:0] POWER_MASK     = 8'h7f;
  localparam logic [2:0] DEV_STEP       = 3'h2;

  // ------------------------------------------------------------
  // timing counts, in divided master clock cycles
  // ------------------------------------------------------------
  localparam logic [2:0]  RESET_DIVIDED_MASTER_CLOCK   = 3'h4;
  localparam logic [11:0] FSYNC_FIRST   = 12'h118; // 280
  localparam logic [3:0]  SCLK_DIV_BASE = 4'h8;
  localparam logic [11:0] RATE_DIV_BASE = 12'h800; // 2048

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       cd;
    logic       rw;
    logic [2:0] dev;
    logic [2:0] addr;
    logic [7:0] data;
  } ccr_word_t;

  // one unit's registers, highest index first
  typedef struct packed {
    logic [15:0] digital_tap_coeff;
    logic        analog_loop_select;     // also analog_tap_silence
    logic        input_polarity_flip;
    logic        single_ended_select;    // also analog_tap_on
    logic [4:0]  analog_tap_coeff;
    logic        test_mode_on;
    logic        digital_tap_on;
    logic        interp_skip;
    logic [4:0]  converter_load_lead;
    logic        mute;
    logic [2:0]  output_gain_sel;
    logic        modulator_reset;
    logic [2:0]  input_gain_sel;
    logic        power_reserved;
    logic        ref_out_use;
    logic        reference_power;
    logic        dac_power;
    logic        adc_power;
    logic        front_amp_power;
    logic        analog_tap_power;
    logic        global_power_on;
    logic        control_echo_on;
    logic [2:0]  master_clock_divide_sel;
    logic [1:0]  serial_clock_divide_sel;
    logic [1:0]  rate_sel;
    logic        soft_reset;
    logic [2:0]  device_count;
    logic        sport_loop;
    logic        digital_loop;
    logic        mixed_mode_on;
    logic        run_mode_sel;
  } ccr_cfg_t;

  typedef struct packed {
    logic analog_tap_power;
    logic front_amp_power;
    logic adc_power;
    logic dac_power;
    logic reference_power;
    logic analog_tap_on;
    logic analog_tap_silence;
    logic samples_valid;
  } ccr_stat_t;

  typedef struct packed {
    logic [NUM_UNITS-1:0][7:0][7:0] regs;
    ccr_stat_t [NUM_UNITS-1:0]      stat;
    logic                           ref_shared;
    logic                           ref_out;
    ccr_word_t                      pend;
    logic                           pend_vld;
    logic [2:0]                     busy;
    logic                           ready;
    ccr_word_t                      out_word;
    logic                           out_vld;
  } ccr_main_st_t;

  typedef struct packed {
    logic [2:0] mcnt;
    logic [2:0] scnt;
    logic       dm_en;
    logic       sc_en;
  } ccr_div_st_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic        first;
    logic        pulse;
  } ccr_fs_st_t;

endpackage

// >>> verification/ccr_host_model.sv
// Purpose: serial port host issuing deframed control words
// Assumes: one word outstanding at a time
// Notes:   word bus shows the inverse of the last word once released
module ccr_host_model (
  input  wire logic          clk_sys_i,
  input  wire logic          ctl_ready_i,
  output logic               ctl_valid_o,
  output ccr_pkg::ccr_word_t ctl_word_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial
  begin
    ctl_valid_o = 1'b0;
    ctl_word_o  = '0;
  end

  // offer a word, hold it until taken, wait out any reset interval
  task automatic send(input ccr_pkg::ccr_word_t w);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    ctl_valid_o <= 1'b1;
    ctl_word_o  <= w;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (ctl_ready_i !== 1'b1 && n < 500);
    ctl_valid_o <= 1'b0;
    ctl_word_o  <= ~w; // no stale value after release
  endtask
endmodule

// >>> verification/ccr_regbank_tb.sv
// Purpose: self-checking bench of the codec control register bank
// Assumes: master divider left at zero, so divided_master_clock enable runs every cycle
// Notes:   table rows first, then power, reset and frame sync cases
module ccr_regbank_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0] d;
    logic [2:0] a;
    logic [7:0] x;
    logic [7:0] e;
  } ccr_row_t;

  localparam ccr_row_t ROWS [0:10] = '{
    '{3'h0, 3'h1, 8'h83, 8'h83},
    '{3'h0, 3'h4, 8'h3f, 8'h3f},
    '{3'h1, 3'h4, 8'hc0, 8'hc0},
    '{3'h0, 3'h3, 8'hff, 8'hff},
    '{3'h1, 3'h3, 8'h08, 8'h08},
    '{3'h0, 3'h5, 8'ha5, 8'ha5},
    '{3'h1, 3'h5, 8'h5a, 8'h5a},
    '{3'h0, 3'h6, 8'h34, 8'h34},
    '{3'h0, 3'h7, 8'h12, 8'h12},
    '{3'h0, 3'h2, 8'h7f, 8'h7f},
    '{3'h1, 3'h2, 8'h20, 8'h20}};

  logic                    clk_sys_i, reset_n_i, pin_n, vld, rdy, ov;
  logic                    fs, dme, sce, rsh, rout;
  logic [63:0]             v;
  ccr_pkg::ccr_word_t      w_in, w_out;
  ccr_pkg::ccr_cfg_t [1:0] cfg;
  ccr_pkg::ccr_stat_t [1:0] st;
  int                      fails, total_checks, n, ovs, dms;

  ccr_regbank ccr_regbank_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .hw_reset_pin_n_i(pin_n), .ctl_valid_i(vld), .ctl_word_i(w_in),
    .ctl_ready_o(rdy), .out_word_o(w_out), .out_valid_o(ov), .cfg_o(cfg),
    .stat_o(st), .ref_shared_o(rsh), .ref_out_o(rout), .divided_master_clock_en_o(dme),
    .sclk_en_o(sce), .output_frame_sync_o(fs));

  ccr_host_model ccr_host_model_inst (.clk_sys_i(clk_sys_i), .ctl_ready_i(rdy),
    .ctl_valid_o(vld), .ctl_word_o(w_in));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // count answer pulses at mid-cycle, where they are settled
  always @(negedge clk_sys_i)
  begin
    if (ov === 1'b1)
      ovs++;
  end

  // send one word, then wait until the bank is ready again
  task automatic put(input logic rw, input logic [2:0] d, a, input logic [7:0] x);
    ccr_host_model_inst.send({1'b1, rw, d, a, x});
    n = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    while (rdy !== 1'b1 && n < 500)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    // a port that never comes back counts as a mismatch
    if (n >= 500)
      fails++;
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // clock and watchdog
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #300us;
    fails++;
    end_of_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    reset_n_i = 1'b0;
    pin_n = 1'b1;
    fails = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (ROWS[i])
    begin
      put(1'b0, ROWS[i].d, ROWS[i].a, ROWS[i].x);
      v = cfg[ROWS[i].d[0]];
      chk(v[ROWS[i].a*8 +: 8], ROWS[i].e);
    end
    chk(cfg[0].digital_tap_coeff, 16'h1234);
    chk({st[0].dac_power, st[1].dac_power, st[1].reference_power, rout, rsh}, 5'h17);
    chk({st[0].analog_tap_on, st[0].analog_tap_silence, st[1].analog_tap_on}, 3'h6);
    put(1'b0, 3'h0, 3'h2, 8'h20);
    chk({st[0].dac_power, st[0].reference_power}, 2'h1);
    put(1'b0, 3'h1, 3'h2, 8'h00);
    chk(rsh, 1'b1);
    put(1'b0, 3'h0, 3'h2, 8'h00);
    chk(rsh, 1'b0);
    chk(w_out, 16'h8200);
    put(1'b1, 3'h0, 3'h3, 8'h00);
    chk(w_out.data, 8'hff);
    chk(16'(ovs), 16'd9);
    put(1'b0, 3'h1, 3'h0, 8'h01);
    chk(st[1].samples_valid, 1'b1);
    put(1'b0, 3'h1, 3'h3, 8'h77);
    chk(cfg[1][31:24], 8'h08);
    put(1'b0, 3'h0, 3'h0, 8'h03);
    put(1'b0, 3'h0, 3'h3, 8'h77);
    chk(cfg[0][31:24], 8'h77);
    put(1'b0, 3'h0, 3'h0, 8'h80);
    // two fixed edges plus n: one apply edge, then four divided clocks
    chk(16'(n + 2), 16'd5);
    chk(|cfg, 1'b0);
    put(1'b0, 3'h0, 3'h3, 8'h11);
    @(posedge clk_sys_i);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({|cfg, rdy}, 2'h0);
    @(posedge clk_sys_i);
    pin_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    while (fs !== 1'b1 && n < 5000);
    chk(n, 16'd280);
    n = 0;
    repeat (16)
    begin
      @(posedge clk_sys_i);
      #1;
      if (sce === 1'b1)
        n++;
      if (dme === 1'b1)
        dms++;
    end
    chk(n, 16'd2);
    chk(16'(dms), 16'd16);
    n = 16;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    while (fs !== 1'b1 && n < 5000);
    chk(n, 16'd2048);
    end_of_test();
  end
endmodule
